// >>> verilog/tssp_top.sv
// slotted serial port: axi4-lite registers, frame engine, three transmitters
//
// Overview of operation
// - transmit slot mask is one 32-bit read/write register, bit n for slot n
// - masked transmit slot: enabled transmitter data outputs released (not driven)
// - masked transmit slot still loads shifter, sets no empty or underrun flag
// - masked transmit slot raises no transmitter empty interrupt
// - word written while empty is serviced goes out in next enabled slot
// - enabled transmit slot loads shifter and sets transmit empty flag
// - receive slot mask is one 32-bit read/write register, bit n for slot n
// - masked receive slot: receivers ignore the data line
// - masked receive slot sets no full or overrun flag, no receive full interrupt
// - enabled receive slot captures the word and sets receive full flag
// - transmit last slot interrupt at start of last slot when enabled
// - receive last slot interrupt after last slot ends when enabled
// - driver enable select set: control line one drives transmitter zero buffer enable
// - select clear, sync mode, transmitter two off: control line one is output flag
// - three independent transmitters on three data lines
// - transmit and receive service requests offered to dma
// - control b receive exception enables at bits 23, 19, 21
// - control b transmit exception enables at bits 22, 18, 20
// - bit clock chain has no fixed divide by two
// - prescaler range bit set bypasses fixed divide by eight
// - no gated clock: bit clock runs regardless of shifter contents
`timescale 1ns/1ps
`default_nettype none
module tssp_top
  import tssp_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sck,
  output logic             fs,
  output logic [2:0]       txd,
  output logic [2:0]       txd_oe,
  input  wire logic        rxd,
  output logic             serial_control_one,
  output logic             serial_control_one_oe,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             tx_exc_irq,
  output logic             rx_exc_irq,
  output logic             tx_last_irq,
  output logic             rx_last_irq,
  output logic             dma_tx_req,
  output logic             dma_rx_req
);
  typedef struct packed {
    logic                  aw_full;
    logic [7:0]            aw_addr;
    logic                  aw_rdy;
    logic                  w_full;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  w_rdy;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  ar_rdy;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [31:0]           ctrl_a;
    logic [31:0]           ctrl_b;
    logic [31:0]           tx_mask;
    logic [31:0]           rx_mask;
    logic [2:0][WORD_W-1:0] txdat;
    logic [WORD_W-1:0]     rx_data;
    logic [WORD_W-1:0]     rx_shift;
    logic                  tx_empty_flag;
    logic                  tx_underrun_flag;
    logic                  rx_full_flag;
    logic                  rx_overrun_flag;
    logic                  sck;
    logic                  fs;
    logic [4:0]            bit_cnt;
    logic [4:0]            slot;
    logic [2:0]            txd_oe;
    logic                  sc1;
    logic                  sc1_oe;
    logic                  tx_irq;
    logic                  rx_irq;
    logic                  tx_exc_irq;
    logic                  rx_exc_irq;
    logic                  tx_last_irq;
    logic                  rx_last_irq;
    logic                  dma_tx_req;
    logic                  dma_rx_req;
  } tssp_st_s;

  localparam logic [4:0] LAST_BIT = 5'(WORD_W - 1);

  tssp_st_s          st, nxt;
  logic              tick;
  logic              run;
  logic [2:0]        lane_load;
  logic [2:0]        lane_shift;
  logic [2:0]        txen;
  logic [4:0]        dc;
  logic [4:0]        ns;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= OFF_RX_MASK);
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction : merge

  assign txen = st.ctrl_b[CB_TXEN_LSB +: 3];
  assign dc   = st.ctrl_a[CA_DC_LSB +: 5];
  assign run  = (|txen) || st.ctrl_b[CB_RXEN];

  tssp_bitclk u_bitclk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (run),
    .prescaler_range_bit     (st.ctrl_a[CA_PSR]),
    .pm      (st.ctrl_a[CA_PM_LSB +: 8]),
    .tick    (tick)
  );

  // each lane loads and shifts on its own enable
  for (genvar g = 0; g < 3; g++) begin : g_lane
    tssp_tx_lane #(
      .WORD_W (WORD_W)
    ) u_lane (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .load    (lane_load[g]),
      .shift   (lane_shift[g]),
      .data    (st.txdat[g]),
      .sout    (txd[g])
    );
  end

  assign s_axi_awready         = st.aw_rdy;
  assign s_axi_wready          = st.w_rdy;
  assign s_axi_bvalid          = st.bvalid;
  assign s_axi_bresp           = st.bresp;
  assign s_axi_arready         = st.ar_rdy;
  assign s_axi_rvalid          = st.rvalid;
  assign s_axi_rdata           = st.rdata;
  assign s_axi_rresp           = st.rresp;
  assign sck                   = st.sck;
  assign fs                    = st.fs;
  assign txd_oe                = st.txd_oe;
  assign serial_control_one    = st.sc1;
  assign serial_control_one_oe = st.sc1_oe;
  assign tx_irq                = st.tx_irq;
  assign rx_irq                = st.rx_irq;
  assign tx_exc_irq            = st.tx_exc_irq;
  assign rx_exc_irq            = st.rx_exc_irq;
  assign tx_last_irq           = st.tx_last_irq;
  assign rx_last_irq           = st.rx_last_irq;
  assign dma_tx_req            = st.dma_tx_req;
  assign dma_rx_req            = st.dma_rx_req;

  always_comb begin
    nxt             = st;
    nxt.tx_last_irq = 1'b0;
    nxt.rx_last_irq = 1'b0;
    lane_load       = '0;
    lane_shift      = '0;
    ns              = (st.slot >= dc) ? 5'h00 : st.slot + 5'h01;

    // bus side; clears come first so that frame events below win
    if (st.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'b0;
    end
    if (st.aw_full && st.w_full && !st.bvalid) begin
      nxt.aw_full = 1'b0;
      nxt.w_full  = 1'b0;
      nxt.bvalid  = 1'b1;
      nxt.bresp   = addr_ok(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (st.aw_addr)
        OFF_CTRL_A:  nxt.ctrl_a  = merge(st.ctrl_a, st.w_data, st.w_strb);
        OFF_CTRL_B:  nxt.ctrl_b  = merge(st.ctrl_b, st.w_data, st.w_strb);
        OFF_TX_MASK: nxt.tx_mask = merge(st.tx_mask, st.w_data, st.w_strb);
        OFF_RX_MASK: nxt.rx_mask = merge(st.rx_mask, st.w_data, st.w_strb);
        OFF_STATUS: begin
          if (st.w_strb[0] && st.w_data[ST_TUE]) begin
            nxt.tx_underrun_flag = 1'b0;
          end
          if (st.w_strb[0] && st.w_data[ST_ROE]) begin
            nxt.rx_overrun_flag = 1'b0;
          end
        end
        OFF_TXD0, OFF_TXD1, OFF_TXD2: begin
          // copied into the shifter at the next slot start, masked or not
          nxt.txdat[st.aw_addr[4:2] - 3'h3] = WORD_W'(merge(32'(st.txdat[st.aw_addr[4:2] - 3'h3]),
                                                            st.w_data, st.w_strb));
          nxt.tx_empty_flag = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (s_axi_awvalid && st.aw_rdy) begin
      nxt.aw_full = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.w_rdy) begin
      nxt.w_full = 1'b1;
      nxt.w_data = s_axi_wdata;
      nxt.w_strb = s_axi_wstrb;
    end

    if (st.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.ar_rdy) begin
      nxt.rvalid = 1'b1;
      nxt.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_CTRL_A:  nxt.rdata = st.ctrl_a;
        OFF_CTRL_B:  nxt.rdata = st.ctrl_b;
        OFF_STATUS:  nxt.rdata = {19'h0, st.slot, 4'h0, st.rx_overrun_flag, st.rx_full_flag, st.tx_underrun_flag, st.tx_empty_flag};
        OFF_TXD0:    nxt.rdata = 32'(st.txdat[0]);
        OFF_TXD1:    nxt.rdata = 32'(st.txdat[1]);
        OFF_TXD2:    nxt.rdata = 32'(st.txdat[2]);
        OFF_TX_MASK: nxt.rdata = st.tx_mask;
        OFF_RX_MASK: nxt.rdata = st.rx_mask;
        OFF_RXD: begin
          nxt.rdata = 32'(st.rx_data);
          nxt.rx_full_flag   = 1'b0;
        end
        default:     nxt.rdata = 32'h0000_0000;
      endcase
    end

    // frame engine
    if (!run) begin
      nxt.sck     = 1'b1;
      nxt.fs      = 1'b0;
      nxt.bit_cnt = LAST_BIT;
      nxt.slot    = SLOT_IDLE;
      nxt.txd_oe  = '0;
    end else if (tick && st.sck) begin
      // drive edge
      nxt.sck = 1'b0;
      nxt.fs  = 1'b0;
      if (st.bit_cnt == LAST_BIT) begin
        nxt.bit_cnt = 5'h00;
        nxt.slot    = ns;
        nxt.fs      = (ns == 5'h00);
        lane_load   = txen; // masked or not, the shifter is reloaded
        nxt.txd_oe  = txen & {3{st.tx_mask[ns]}};
        if (st.tx_mask[ns] && (|txen)) begin
          nxt.tx_underrun_flag = nxt.tx_underrun_flag || st.tx_empty_flag;
          nxt.tx_empty_flag = 1'b1;
        end
        nxt.tx_last_irq = (ns == dc) && st.ctrl_b[CB_TX_LAST_SLOT_IRQ_EN];
      end else begin
        nxt.bit_cnt = st.bit_cnt + 5'h01;
        lane_shift  = txen;
      end
    end else if (tick) begin
      // sample edge
      nxt.sck = 1'b1;
      if (st.ctrl_b[CB_RXEN] && st.slot <= dc) begin
        nxt.rx_shift = {st.rx_shift[WORD_W-2:0], rxd};
        if (st.bit_cnt == LAST_BIT) begin
          if (st.rx_mask[st.slot]) begin
            nxt.rx_data = {st.rx_shift[WORD_W-2:0], rxd};
            nxt.rx_overrun_flag     = nxt.rx_overrun_flag || st.rx_full_flag;
            nxt.rx_full_flag     = 1'b1;
          end
          nxt.rx_last_irq = (st.slot == dc) && st.ctrl_b[CB_RX_LAST_SLOT_IRQ_EN];
        end
      end
    end

    // line one: buffer enable, else flag output in sync mode with tx2 off
    if (nxt.ctrl_a[CA_DES]) begin
      nxt.sc1    = nxt.txd_oe[0];
      nxt.sc1_oe = 1'b1;
    end else if (nxt.ctrl_a[CA_SYNC] && !nxt.ctrl_b[CB_TXEN_LSB + 2]) begin
      nxt.sc1    = nxt.ctrl_a[CA_FLAG];
      nxt.sc1_oe = 1'b1;
    end else begin
      nxt.sc1    = 1'b0;
      nxt.sc1_oe = 1'b0;
    end

    // flags only rise in enabled slots, so requests follow them
    nxt.tx_irq     = nxt.tx_empty_flag && nxt.ctrl_b[CB_TIE];
    nxt.rx_irq     = nxt.rx_full_flag && nxt.ctrl_b[CB_RIE];
    nxt.tx_exc_irq = nxt.tx_empty_flag && nxt.tx_underrun_flag && nxt.ctrl_b[CB_TEIE];
    nxt.rx_exc_irq = nxt.rx_full_flag && nxt.rx_overrun_flag && nxt.ctrl_b[CB_REIE];
    nxt.dma_tx_req = nxt.tx_empty_flag && (|nxt.ctrl_b[CB_TXEN_LSB +: 3]);
    nxt.dma_rx_req = nxt.rx_full_flag && nxt.ctrl_b[CB_RXEN];
    nxt.aw_rdy     = !nxt.aw_full && !nxt.bvalid;
    nxt.w_rdy      = !nxt.w_full && !nxt.bvalid;
    nxt.ar_rdy     = !nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.ctrl_a  <= CTRL_A_RST;
      st.ctrl_b  <= CTRL_B_RST;
      st.tx_mask <= MASK_RST;
      st.rx_mask <= MASK_RST;
      st.sck     <= 1'b1;
      st.bit_cnt <= LAST_BIT;
      st.slot    <= SLOT_IDLE;
      st.aw_rdy  <= 1'b1;
      st.w_rdy   <= 1'b1;
      st.ar_rdy  <= 1'b1;
    end else if (ce) begin
      st <= nxt;
    end
  end
endmodule : tssp_top
`default_nettype wire

// >>> verilog/tssp_pkg.sv
// constants shared by the slotted serial port files
package tssp_pkg;
  localparam logic [7:0]  OFF_CTRL_A  = 8'h00;
  localparam logic [7:0]  OFF_CTRL_B  = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_TXD0    = 8'h0c;
  localparam logic [7:0]  OFF_TXD1    = 8'h10;
  localparam logic [7:0]  OFF_TXD2    = 8'h14;
  localparam logic [7:0]  OFF_RXD     = 8'h18;
  localparam logic [7:0]  OFF_TX_MASK = 8'h1c;
  localparam logic [7:0]  OFF_RX_MASK = 8'h20;
  localparam int          CA_PM_LSB   = 0;
  localparam int          CA_PSR      = 8;
  localparam int          CA_DC_LSB   = 9;
  localparam int          CA_DES      = 16;
  localparam int          CA_SYNC     = 17;
  localparam int          CA_FLAG     = 18;
  localparam int          CB_TXEN_LSB = 0;
  localparam int          CB_RXEN     = 3;
  localparam int          CB_TIE      = 18;
  localparam int          CB_RIE      = 19;
  localparam int          CB_TX_LAST_SLOT_IRQ_EN     = 20;
  localparam int          CB_RX_LAST_SLOT_IRQ_EN     = 21;
  localparam int          CB_TEIE     = 22;
  localparam int          CB_REIE     = 23;
  localparam int          ST_TDE      = 0;
  localparam int          ST_TUE      = 1;
  localparam int          ST_RDF      = 2;
  localparam int          ST_ROE      = 3;
  localparam int          ST_SLOT_LSB = 8;
  localparam logic [31:0] CTRL_A_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_B_RST  = 32'h0000_0000;
  localparam logic [31:0] MASK_RST    = 32'hffff_ffff;
  localparam logic [4:0]  SLOT_IDLE   = 5'h1f;
  localparam logic [2:0]  FIXED_DIV_MAX = 3'h7;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : tssp_pkg

// >>> verilog/tssp_bitclk.sv
// internal bit clock chain: optional fixed /8 then programmable modulus
`timescale 1ns/1ps
`default_nettype none
module tssp_bitclk
  import tssp_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       prescaler_range_bit,
  input  wire logic [7:0] pm,
  output logic            tick
);
  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] cnt;
    logic       tick;
  } tssp_bc_s;

  tssp_bc_s st, nxt;
  logic     pre_done;

  assign tick = st.tick;

  always_comb begin
    nxt      = st;
    nxt.tick = 1'b0;
    pre_done = prescaler_range_bit || (st.pre == FIXED_DIV_MAX);
    if (!run) begin
      nxt.pre = '0;
      nxt.cnt = '0;
    end else begin
      // free running while enabled, data or not
      nxt.pre = prescaler_range_bit ? 3'h0 : st.pre + 3'h1;
      if (pre_done) begin
        if (st.cnt == pm) begin
          nxt.cnt  = '0;
          nxt.tick = 1'b1; // one tick per sck edge, no trailing /2 stage
        end else begin
          nxt.cnt = st.cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt;
    end
  end
endmodule : tssp_bitclk
`default_nettype wire

// >>> verilog/tssp_tx_lane.sv
// one transmit shift register, msb first
`timescale 1ns/1ps
`default_nettype none
module tssp_tx_lane #(
  parameter int WORD_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              load,
  input  wire logic              shift,
  input  wire logic [WORD_W-1:0] data,
  output logic                   sout
);
  typedef struct packed {
    logic [WORD_W-1:0] sh;
  } tssp_lane_s;

  tssp_lane_s st, nxt;

  assign sout = st.sh[WORD_W-1];

  always_comb begin
    nxt = st;
    if (load) begin
      nxt.sh = data;
    end else if (shift) begin
      nxt.sh = {st.sh[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt;
    end
  end
endmodule : tssp_tx_lane
`default_nettype wire

// >>> verif/tssp_top_properties.sv
// concurrent checks on the slot port pins
`timescale 1ns/1ps
`default_nettype none
module tssp_props (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sck,
  input  wire logic [2:0] txd_oe,
  input  wire logic       tx_last_irq,
  input  wire logic       rx_last_irq,
  input  wire logic       dma_tx_req,
  input  wire logic       dma_rx_req,
  input  wire logic       s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic       s_axi_rvalid,
  input  wire logic       s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tx_last_fall;
    tx_last_irq |-> $fell(sck);
  endproperty
  a_tx_last_fall: assert property (p_tx_last_fall) else $error("tx last pulse off sck fall");
  property p_tx_last_one;
    tx_last_irq |=> !tx_last_irq [*8];
  endproperty
  a_tx_last_one: assert property (p_tx_last_one) else $error("tx last pulse too long");
  property p_rx_last_rise;
    rx_last_irq |-> $rose(sck);
  endproperty
  a_rx_last_rise: assert property (p_rx_last_rise) else $error("rx last pulse off sck rise");
  // a lane may only start driving where a slot starts
  property p_oe_slot;
    (txd_oe & ~$past(txd_oe)) != 3'h0 |-> $fell(sck);
  endproperty
  a_oe_slot: assert property (p_oe_slot) else $error("txd_oe rose mid slot");
  property p_tde_slot;
    $rose(dma_tx_req) |-> $fell(sck);
  endproperty
  a_tde_slot: assert property (p_tde_slot) else $error("tx request off slot load");
  property p_rdf_rise;
    $rose(dma_rx_req) |-> $rose(sck);
  endproperty
  a_rdf_rise: assert property (p_rdf_rise) else $error("rx request off sck rise");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid held after accept");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid held after accept");
  c_tx_last: cover property (tx_last_irq);
  c_rx_last: cover property (rx_last_irq);
  c_tde: cover property ($rose(dma_tx_req));
endmodule : tssp_props
bind tssp_top tssp_props tssp_props_inst (
  .aclk(aclk), .aresetn(aresetn), .sck(sck), .txd_oe(txd_oe),
  .tx_last_irq(tx_last_irq), .rx_last_irq(rx_last_irq),
  .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// >>> verif/tssp_codec_model.sv
// behavioural codec on the far side of the slot port
`timescale 1ns/1ps
`default_nettype none
module tssp_codec_model #(
  parameter logic [15:0] WORD = 16'hc3a5
) (
  input  wire logic  sck,
  input  wire logic  fs,
  input  wire logic  txd0,
  input  wire logic  txd0_oe,
  output logic       rxd,
  output logic [15:0] heard
);
  int          bit_i = 0;
  logic [15:0] sh    = 16'h0;
  initial rxd = WORD[15];
  initial heard = 16'h0;
  // rxd moves on the fall so it is steady at the sampling rise
  always @(negedge sck) rxd = WORD[15-bit_i];
  always @(posedge sck) begin
    // a released line is ignored, never read as a level
    if (txd0_oe) sh = {sh[14:0], txd0};
    if (txd0_oe && bit_i == 15) heard = sh;
    bit_i = fs ? 1 : (bit_i + 1) % 16;
  end
endmodule : tssp_codec_model
`default_nettype wire

// >>> verif/tssp_top_tb.sv
// self-checking bench for the slotted serial port
`timescale 1ns/1ps
`default_nettype none
module tssp_top_tb;
  import tssp_pkg::*;
  localparam int WW   = 16;
  localparam int SLOT = 2 * WW;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  aw_a = 8'h0, ar_a = 8'h0;
  logic [31:0] w_d = 32'h0, r_d;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        aw_r, w_r, b_v, ar_r, r_v, sck, fs, rxd, sc1, sc1_oe;
  logic        tx_irq, rx_irq, tl_irq, rl_irq, dtx, drx, tx_exc, rx_exc;
  logic [1:0]  b_resp, r_resp, last_b, last_r;
  logic [2:0]  txd, txd_oe;
  logic [15:0] heard;
  int          failures = 0, compares = 0, cyc = 0, tl_n = 0, rl_n = 0;
  tssp_top #(.WORD_W(WW)) tssp_top_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .sck(sck), .fs(fs), .txd(txd), .txd_oe(txd_oe), .rxd(rxd),
    .serial_control_one(sc1), .serial_control_one_oe(sc1_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_exc_irq(tx_exc), .rx_exc_irq(rx_exc),
    .tx_last_irq(tl_irq), .rx_last_irq(rl_irq), .dma_tx_req(dtx), .dma_rx_req(drx)
  );
  tssp_codec_model tssp_codec_model_inst (
    .sck(sck), .fs(fs), .txd0(txd[0]), .txd0_oe(txd_oe[0]), .rxd(rxd), .heard(heard)
  );
  always #2.5 aclk = ~aclk;
  task automatic finish_test;
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // ceiling well above the thousand or so cycles the scenarios need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    tl_n <= tl_n + int'(tl_irq === 1'b1);
    rl_n <= rl_n + int'(rl_irq === 1'b1);
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (b_v) begin
        last_b = b_resp;
        b_r <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (ar_r) ar_v <= 1'b0;
      if (r_v) begin
        d = r_d;
        last_r = r_resp;
        r_r <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rd_chk
  task automatic upto(input int c);
    while (cyc < c) @(negedge aclk);
  endtask : upto
  task automatic t_regs;
    rd_chk(OFF_CTRL_A, CTRL_A_RST);
    rd_chk(OFF_CTRL_B, CTRL_B_RST);
    rd_chk(OFF_TX_MASK, MASK_RST);
    rd_chk(OFF_RX_MASK, MASK_RST);
    wr(OFF_TX_MASK, 32'ha5a5_0f0f);
    rd_chk(OFF_TX_MASK, 32'ha5a5_0f0f);
    wr(OFF_RX_MASK, 32'h5a5a_f0f0);
    rd_chk(OFF_RX_MASK, 32'h5a5a_f0f0);
    wr(OFF_CTRL_B, 32'h00fc_0000);
    rd_chk(OFF_CTRL_B, 32'h00fc_0000);
    wr(OFF_CTRL_B, 32'h0);
    rd_chk(8'h24, 32'h0);
    chk(last_r, RESP_SLVERR);
    wr(8'h24, 32'hffff_ffff);
    chk(last_b, RESP_SLVERR);
  endtask : t_regs
  task automatic t_clk;
    logic [31:0] ca [3];
    int          hp [3];
    int          n;
    ca = '{32'h100, 32'h102, 32'h0};
    hp = '{1, 3, 8};
    for (int i = 0; i < 3; i++) begin
      wr(OFF_TXD0, 32'h0);
      wr(OFF_CTRL_A, ca[i]);
      wr(OFF_CTRL_B, 32'h1);
      while (sck !== 1'b1) @(negedge aclk);
      while (sck !== 1'b0) @(negedge aclk);
      n = 0;
      while (sck === 1'b0) begin
        @(negedge aclk);
        n++;
      end
      chk(n, hp[i]);
      wr(OFF_CTRL_B, 32'h0);
    end
  endtask : t_clk
  task automatic t_tx;
    int          t0, t1, n0;
    logic [31:0] d;
    wr(OFF_TX_MASK, 32'h5);
    wr(OFF_TXD0, 32'h1111);
    wr(OFF_TXD1, 32'h3333);
    wr(OFF_TXD2, 32'h4444);
    wr(OFF_CTRL_A, 32'h0001_0700);
    wr(OFF_CTRL_B, 32'h0054_0007);
    do @(negedge aclk); while (tx_irq !== 1'b1);
    t0 = cyc;
    n0 = tl_n;
    chk({fs, txd_oe}, 4'b1111);
    chk({sc1_oe, sc1}, 2'b11);
    chk(dtx, 1'b1);
    chk(tx_exc, 1'b0);
    // bit 12 of each lane word: lanes shift independently
    upto(t0 + 6);
    chk({fs, txd}, 4'b0011);
    wr(OFF_TXD0, 32'h2222);
    @(negedge aclk);
    chk(dtx, 1'b0);
    upto(t0 + SLOT + 8);
    chk(heard, 16'h1111);
    chk(txd_oe, 3'b000);
    chk({sc1_oe, sc1}, 2'b10);
    do @(negedge aclk); while (tx_irq !== 1'b1);
    t1 = cyc;
    chk(t1 - t0, 2 * SLOT);
    upto(t0 + 3 * SLOT + 16);
    chk(heard, 16'h2222);
    rd(OFF_STATUS, d);
    chk(d[1:0], 2'b01);
    upto(t0 + 4 * SLOT + 8);
    chk(tl_n - n0, 1);
    chk(tx_exc, 1'b1);
    rd(OFF_STATUS, d);
    chk(d[1:0], 2'b11);
    wr(OFF_STATUS, 32'h0000_0002);
    rd(OFF_STATUS, d);
    chk(d[1:0], 2'b01);
    wr(OFF_CTRL_B, 32'h0004_0007);
    n0 = tl_n;
    upto(t0 + 9 * SLOT);
    chk(tl_n - n0, 0);
    wr(OFF_CTRL_B, 32'h0);
  endtask : t_tx
  task automatic t_rx;
    int          t0, t1, n0;
    logic [31:0] d;
    wr(OFF_RX_MASK, 32'h2);
    rd(OFF_RXD, d);
    wr(OFF_CTRL_A, 32'h0000_0700);
    wr(OFF_CTRL_B, 32'h0028_0008);
    do @(negedge aclk); while (rx_irq !== 1'b1);
    t0 = cyc;
    n0 = rl_n;
    chk(drx, 1'b1);
    rd_chk(OFF_RXD, 32'h0000_c3a5);
    do @(negedge aclk); while (rx_irq !== 1'b1);
    t1 = cyc;
    chk(t1 - t0, 4 * SLOT);
    chk(rl_n - n0, 1);
    // word left unread so the next enabled slot overruns
    wr(OFF_CTRL_B, 32'h0088_0008);
    n0 = rl_n;
    upto(t1 + 6 * SLOT);
    chk(rl_n - n0, 0);
    chk(rx_exc, 1'b1);
    wr(OFF_CTRL_B, 32'h0);
  endtask : t_rx
  task automatic t_flag;
    logic [31:0] ca [4];
    logic [31:0] cb [4];
    logic [1:0]  ex [4];
    ca = '{32'h6_0000, 32'h2_0000, 32'h6_0000, 32'h4_0000};
    cb = '{32'h3, 32'h3, 32'h7, 32'h1};
    ex = '{2'b11, 2'b10, 2'b00, 2'b00};
    for (int i = 0; i < 4; i++) begin
      wr(OFF_TXD0, 32'h0);
      wr(OFF_CTRL_A, ca[i]);
      wr(OFF_CTRL_B, cb[i]);
      repeat (2) @(negedge aclk);
      chk({sc1_oe, sc1 & sc1_oe}, ex[i]);
      wr(OFF_CTRL_B, 32'h0);
    end
  endtask : t_flag
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_clk();
    t_tx();
    t_rx();
    t_flag();
    finish_test();
  end
endmodule : tssp_top_tb
`default_nettype wire
